// ==== src/svt_pattern_gen.sv ====
// Training and bit-error-test pattern source.
`timescale 1ns/1ps
`default_nettype none
module svt_pattern_gen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	input wire logic advance,
	input wire logic test_mode,
	output logic [34:0] pat_word
);
	logic phase; // Training word polarity
	logic [30:0] lfsr; // Test sequence state
	logic next_phase;
	logic [30:0] next_lfsr;
	logic [34:0] next_pat_word;

	// Alternate training word, or step the 31-bit sequence in test mode
	always_comb begin
		next_phase = phase;
		next_lfsr = lfsr;
		if (restart) begin
			next_phase = 1'b0;
			next_lfsr = svt_pkg::PRBS_SEED;
		end else if (advance) begin
			next_phase = ~phase;
			next_lfsr = {lfsr[29:0], lfsr[30] ^ lfsr[27]};
		end
		next_pat_word = test_mode ? {next_lfsr[3:0], next_lfsr}
			: (next_phase ? ~svt_pkg::TRAIN_PATTERN : svt_pkg::TRAIN_PATTERN);
	end

	// Pattern registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 1'b0;
			lfsr <= svt_pkg::PRBS_SEED;
			pat_word <= svt_pkg::TRAIN_PATTERN;
		end else begin
			phase <= next_phase;
			lfsr <= next_lfsr;
			pat_word <= next_pat_word;
		end
	end
endmodule
`default_nettype wire

// ==== src/svt_pixel_capture.sv ====
// Pixel bus capture at the selected pixel clock edge.
`timescale 1ns/1ps
`default_nettype none
module svt_pixel_capture (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pixel_clock_in,
	input wire logic edge_select,
	input wire logic polarity_flip_n,
	input wire logic width24,
	input wire logic [9:0] red_pixel_bits,
	input wire logic [9:0] green_pixel_bits,
	input wire logic [9:0] blue_pixel_bits,
	input wire logic [1:0] user_data_bits,
	input wire logic video_active,
	input wire logic line_sync,
	input wire logic frame_sync,
	output logic cap_valid,
	output logic [34:0] cap_word
);
	// Drop the two low colour bits in 24-bit mode
	function automatic logic [9:0] narrow(input logic [9:0] c, input logic w24);
		narrow = w24 ? {c[9:svt_pkg::NARROW_LSBS], 2'h0} : c;
	endfunction

	logic clk_q; // Pixel clock one cycle ago
	logic next_clk_q;
	logic next_cap_valid;
	logic [34:0] next_cap_word;
	logic edge_hit; // Selected edge seen this cycle

	// Edge select and word assembly
	always_comb begin
		next_clk_q = pixel_clock_in;
		edge_hit = edge_select ? (pixel_clock_in & ~clk_q) : (~pixel_clock_in & clk_q);
		next_cap_valid = edge_hit;
		next_cap_word = cap_word;
		if (edge_hit) begin
			next_cap_word[svt_pkg::LW_ACT] = video_active ^ ~polarity_flip_n;
			next_cap_word[svt_pkg::LW_HS] = line_sync;
			next_cap_word[svt_pkg::LW_VS] = frame_sync;
			next_cap_word[32:3] = {narrow(red_pixel_bits, width24),
				narrow(green_pixel_bits, width24), narrow(blue_pixel_bits, width24)};
			// User bits only ride along in 32-bit mode
			next_cap_word[34:33] = width24 ? 2'h0 : user_data_bits;
		end
	end

	// Capture registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_q <= 1'b0;
			cap_valid <= 1'b0;
			cap_word <= '0;
		end else begin
			clk_q <= next_clk_q;
			cap_valid <= next_cap_valid;
			cap_word <= next_cap_word;
		end
	end

	property p_edge_capture;
		@(posedge pclk) disable iff (!presetn)
		(edge_select && pixel_clock_in && !clk_q) |=> cap_valid;
	endproperty
	a_edge_capture: assert property (p_edge_capture) else $error("rising edge missed");

	property p_de_polarity;
		@(posedge pclk) disable iff (!presetn)
		cap_valid |-> cap_word[0] == ($past(video_active) ^ !$past(polarity_flip_n));
	endproperty
	a_de_polarity: assert property (p_de_polarity) else $error("active flag polarity");
endmodule
`default_nettype wire

// ==== src/svt_pkg.sv ====
// Shared constants, register map and state type of the serial video transmit front end.
// Summary of operation
// - Carry 32 payload plus 3 sync bits
// - Exactly one serial output lane
// - User bits used only in 32-bit mode
// - Width strap high selects 24-bit, low 32-bit
// - Low-frequency strap high selects low range
// - Power-down pin low powers the block down
// - Polarity strap low inverts video active
// - Edge strap picks rising or falling capture
// - Tester strap high enters bit-error test
// - Emphasis strap high enables pre-emphasis
// - Swing strap high normal, low weak drive
// - Active sends pixels, inactive sends sync
// - Hot-plug low starts training pattern
// - Lock low ends training, normal data follows
// - Power-down drives both serial lines high
package svt_pkg;
	// Lane word geometry
	localparam int COLOR_W = 10;
	localparam int USER_W = 2;
	localparam int LANE_W = 35;
	localparam int NARROW_LSBS = 2;
	// Lane word field positions
	localparam int LW_ACT = 0;
	localparam int LW_HS = 1;
	localparam int LW_VS = 2;
	localparam int LW_PAY_LSB = 3;
	localparam int LW_USER_LSB = 33;
	// Register byte offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_PIXCNT = 12'h008;
	// Control register layout and reset value
	localparam int CTRL_HPD_IGNORE = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Status register bit positions
	localparam int ST_LOCK_BIT = 3;
	localparam int ST_HPD_BIT = 4;
	localparam int ST_W24_BIT = 5;
	localparam int ST_LF_BIT = 6;
	localparam int ST_EMPH_BIT = 7;
	localparam int ST_SWING_BIT = 8;
	localparam int ST_PWR_BIT = 9;
	// Lane word kinds
	localparam logic [1:0] KIND_IDLE = 2'h0;
	localparam logic [1:0] KIND_PIXEL = 2'h1;
	localparam logic [1:0] KIND_SYNC = 2'h2;
	localparam logic [1:0] KIND_PATTERN = 2'h3;
	// Test patterns
	localparam logic [34:0] TRAIN_PATTERN = 35'h5_5555_5555;
	localparam logic [30:0] PRBS_SEED = 31'h7FFF_FFFF;
	// Strap reset values
	localparam logic W24_RESET = 1'b0;
	localparam logic LF_RESET = 1'b0;
	// Link states
	typedef enum logic [2:0] {ST_OFF, ST_WAIT_HPD, ST_TRAIN, ST_NORMAL, ST_TEST} svt_state_t;
endpackage

// ==== src/svt_tx_frontend.sv ====
// Top of the serial video transmit front end: straps, link states, lane words, APB registers.
`timescale 1ns/1ps
`default_nettype none
module svt_tx_frontend (
	input wire logic pclk,
	input wire logic presetn,
	// Parallel pixel bus
	input wire logic pixel_clock_in,
	input wire logic [9:0] red_pixel_bits,
	input wire logic [9:0] green_pixel_bits,
	input wire logic [9:0] blue_pixel_bits,
	input wire logic [1:0] user_data_bits,
	input wire logic video_active,
	input wire logic line_sync,
	input wire logic frame_sync,
	// Straps
	input wire logic power_down_n,
	input wire logic width_select,
	input wire logic low_freq_select,
	input wire logic polarity_flip_n,
	input wire logic edge_select,
	input wire logic field_tester_enable,
	input wire logic emphasis_select,
	input wire logic swing_select,
	// Receiver handshake
	input wire logic hot_plug_n,
	input wire logic rx_lock_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Lane side
	output logic [34:0] lane_word,
	output logic [1:0] lane_kind,
	output logic lane_valid,
	output logic serial_out_p,
	output logic serial_out_n,
	output logic emphasis_en,
	output logic swing_normal,
	output logic width24_mode,
	output logic low_freq_mode
);
	svt_pkg::svt_state_t state; // Link state
	svt_pkg::svt_state_t next_state;
	logic pd_q; // Power-down pin one cycle ago
	logic next_pd_q;
	logic next_width24;
	logic next_low_freq;
	logic next_emphasis;
	logic next_swing;
	logic hpd_ok; // Receiver present, or hot-plug ignored
	logic pd_rise; // Leaving power-down this cycle
	logic cap_valid;
	logic [34:0] cap_word;
	logic [34:0] pat_word;
	logic pat_restart;
	logic pat_advance;
	logic [34:0] next_lane_word;
	logic [1:0] next_lane_kind;
	logic next_lane_valid;
	logic next_serial_p;
	logic next_serial_n;
	logic [31:0] ctrl; // Software control word
	logic [31:0] next_ctrl;
	logic [31:0] pix_count; // Pixel words sent
	logic [31:0] next_pix_count;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic apb_setup;
	logic apb_write;
	logic addr_hit;
	logic [31:0] status_word;

	// Capture stage, clocked from the system clock with the pixel clock sampled
	svt_pixel_capture u_capture (
		.pclk(pclk),
		.presetn(presetn),
		.pixel_clock_in(pixel_clock_in),
		.edge_select(edge_select),
		.polarity_flip_n(polarity_flip_n),
		.width24(width24_mode),
		.red_pixel_bits(red_pixel_bits),
		.green_pixel_bits(green_pixel_bits),
		.blue_pixel_bits(blue_pixel_bits),
		.user_data_bits(user_data_bits),
		.video_active(video_active),
		.line_sync(line_sync),
		.frame_sync(frame_sync),
		.cap_valid(cap_valid),
		.cap_word(cap_word)
	);

	// Training and test pattern source
	svt_pattern_gen u_pattern (
		.pclk(pclk),
		.presetn(presetn),
		.restart(pat_restart),
		.advance(pat_advance),
		.test_mode(state == svt_pkg::ST_TEST),
		.pat_word(pat_word)
	);

	// Link state machine
	always_comb begin
		hpd_ok = ~hot_plug_n | ctrl[svt_pkg::CTRL_HPD_IGNORE];
		next_state = state;
		if (!power_down_n) begin
			next_state = svt_pkg::ST_OFF;
		end else begin
			case (state)
				svt_pkg::ST_OFF: begin
					// Always retrain from the start after power-down
					next_state = svt_pkg::ST_WAIT_HPD;
				end
				svt_pkg::ST_WAIT_HPD: begin
					if (field_tester_enable) begin
						next_state = svt_pkg::ST_TEST;
					end else if (hpd_ok) begin
						next_state = svt_pkg::ST_TRAIN;
					end
				end
				svt_pkg::ST_TRAIN: begin
					if (field_tester_enable) begin
						next_state = svt_pkg::ST_TEST;
					end else if (!hpd_ok) begin
						next_state = svt_pkg::ST_WAIT_HPD;
					end else if (!rx_lock_n) begin
						next_state = svt_pkg::ST_NORMAL;
					end
				end
				svt_pkg::ST_NORMAL: begin
					// Lost lock falls back to training rather than sending blind
					if (field_tester_enable) begin
						next_state = svt_pkg::ST_TEST;
					end else if (!hpd_ok) begin
						next_state = svt_pkg::ST_WAIT_HPD;
					end else if (rx_lock_n) begin
						next_state = svt_pkg::ST_TRAIN;
					end
				end
				svt_pkg::ST_TEST: begin
					if (!field_tester_enable) begin
						next_state = svt_pkg::ST_WAIT_HPD;
					end
				end
				default: begin
					next_state = svt_pkg::ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= svt_pkg::ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// Strap sampling; width and range are taken only when leaving power-down
	always_comb begin
		next_pd_q = power_down_n;
		pd_rise = power_down_n & ~pd_q;
		next_width24 = width24_mode;
		next_low_freq = low_freq_mode;
		if (pd_rise) begin
			next_width24 = width_select;
			next_low_freq = low_freq_select;
		end
		// Drive options follow their pins, and fall away in power-down
		next_emphasis = emphasis_select & power_down_n;
		next_swing = swing_select & power_down_n;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_q <= 1'b0;
			width24_mode <= svt_pkg::W24_RESET;
			low_freq_mode <= svt_pkg::LF_RESET;
			emphasis_en <= 1'b0;
			swing_normal <= 1'b0;
		end else begin
			pd_q <= next_pd_q;
			width24_mode <= next_width24;
			low_freq_mode <= next_low_freq;
			emphasis_en <= next_emphasis;
			swing_normal <= next_swing;
		end
	end

	// Lane word selection for the single serial lane
	always_comb begin
		pat_restart = (next_state == svt_pkg::ST_TRAIN && state != svt_pkg::ST_TRAIN)
			|| (next_state == svt_pkg::ST_TEST && state != svt_pkg::ST_TEST);
		pat_advance = cap_valid && (state == svt_pkg::ST_TRAIN || state == svt_pkg::ST_TEST);
		next_lane_word = lane_word;
		next_lane_kind = lane_kind;
		next_lane_valid = 1'b0;
		if (next_state == svt_pkg::ST_OFF) begin
			next_lane_word = '0;
			next_lane_kind = svt_pkg::KIND_IDLE;
		end else if (cap_valid && state == svt_pkg::ST_NORMAL) begin
			next_lane_valid = 1'b1;
			if (cap_word[svt_pkg::LW_ACT]) begin
				// Full 32-bit payload plus the three sync flags
				next_lane_word = cap_word;
				next_lane_kind = svt_pkg::KIND_PIXEL;
			end else begin
				// Blanking carries only the sync flags
				next_lane_word = {32'h0000_0000, cap_word[2:0]};
				next_lane_kind = svt_pkg::KIND_SYNC;
			end
		end else if (pat_advance) begin
			next_lane_valid = 1'b1;
			next_lane_word = pat_word;
			next_lane_kind = svt_pkg::KIND_PATTERN;
		end
		// One pair only; bit timing belongs to the analog serializer
		if (next_state == svt_pkg::ST_OFF) begin
			next_serial_p = 1'b1;
			next_serial_n = 1'b1;
		end else begin
			next_serial_p = ^next_lane_word;
			next_serial_n = ~(^next_lane_word);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lane_word <= '0;
			lane_kind <= svt_pkg::KIND_IDLE;
			lane_valid <= 1'b0;
			serial_out_p <= 1'b1;
			serial_out_n <= 1'b1;
		end else begin
			lane_word <= next_lane_word;
			lane_kind <= next_lane_kind;
			lane_valid <= next_lane_valid;
			serial_out_p <= next_serial_p;
			serial_out_n <= next_serial_n;
		end
	end

	// APB slave: zero-wait access phase, data prepared during setup
	always_comb begin
		apb_setup = psel & ~penable;
		apb_write = psel & penable & pready & pwrite;
		addr_hit = (paddr == svt_pkg::REG_CTRL) || (paddr == svt_pkg::REG_STATUS)
			|| (paddr == svt_pkg::REG_PIXCNT);
		status_word = '0;
		status_word[2:0] = 3'(state);
		status_word[svt_pkg::ST_LOCK_BIT] = ~rx_lock_n;
		status_word[svt_pkg::ST_HPD_BIT] = hpd_ok;
		status_word[svt_pkg::ST_W24_BIT] = width24_mode;
		status_word[svt_pkg::ST_LF_BIT] = low_freq_mode;
		status_word[svt_pkg::ST_EMPH_BIT] = emphasis_en;
		status_word[svt_pkg::ST_SWING_BIT] = swing_normal;
		status_word[svt_pkg::ST_PWR_BIT] = power_down_n;
		next_pready = apb_setup;
		next_pslverr = apb_setup & ~addr_hit;
		next_prdata = '0;
		if (apb_setup && !pwrite) begin
			case (paddr)
				svt_pkg::REG_CTRL: next_prdata = ctrl;
				svt_pkg::REG_STATUS: next_prdata = status_word;
				svt_pkg::REG_PIXCNT: next_prdata = pix_count;
				default: next_prdata = '0;
			endcase
		end
		next_ctrl = ctrl;
		if (apb_write && paddr == svt_pkg::REG_CTRL) begin
			next_ctrl = {31'h0000_0000, pwdata[svt_pkg::CTRL_HPD_IGNORE]};
		end
		// A pixel sent in the clearing cycle still counts
		next_pix_count = pix_count;
		if (apb_write && paddr == svt_pkg::REG_PIXCNT) begin
			next_pix_count = '0;
		end
		if (next_lane_valid && next_lane_kind == svt_pkg::KIND_PIXEL) begin
			next_pix_count = next_pix_count + 32'h0000_0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			ctrl <= svt_pkg::CTRL_RESET;
			pix_count <= '0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			ctrl <= next_ctrl;
			pix_count <= next_pix_count;
		end
	end

	property p_pd_lines_high;
		@(posedge pclk) disable iff (!presetn)
		!power_down_n |=> serial_out_p && serial_out_n && state == svt_pkg::ST_OFF;
	endproperty
	a_pd_lines_high: assert property (p_pd_lines_high) else $error("lines not high");

	property p_pd_state;
		@(posedge pclk) disable iff (!presetn)
		power_down_n && state == svt_pkg::ST_OFF |=> state == svt_pkg::ST_WAIT_HPD;
	endproperty
	a_pd_state: assert property (p_pd_state) else $error("power-up not restarted");

	property p_user_masked;
		@(posedge pclk) disable iff (!presetn)
		lane_valid && lane_kind == svt_pkg::KIND_PIXEL && width24_mode |-> lane_word[34:33] == 2'h0;
	endproperty
	a_user_masked: assert property (p_user_masked) else $error("user bits in 24-bit");

	property p_width_strap;
		@(posedge pclk) disable iff (!presetn)
		power_down_n && !pd_q |=> width24_mode == $past(width_select);
	endproperty
	a_width_strap: assert property (p_width_strap) else $error("width strap missed");

	property p_freq_strap;
		@(posedge pclk) disable iff (!presetn)
		(power_down_n && pd_q) ##1 (power_down_n && pd_q) |-> $stable(low_freq_mode);
	endproperty
	a_freq_strap: assert property (p_freq_strap) else $error("range changed live");

	property p_drive_opts;
		@(posedge pclk) disable iff (!presetn)
		power_down_n |=> emphasis_en == $past(emphasis_select) && swing_normal == $past(swing_select);
	endproperty
	a_drive_opts: assert property (p_drive_opts) else $error("drive options wrong");

	property p_test_entry;
		@(posedge pclk) disable iff (!presetn)
		field_tester_enable && power_down_n && state != svt_pkg::ST_OFF |=> state == svt_pkg::ST_TEST;
	endproperty
	a_test_entry: assert property (p_test_entry) else $error("test mode not entered");

	property p_train_start;
		@(posedge pclk) disable iff (!presetn)
		state == svt_pkg::ST_WAIT_HPD && !hot_plug_n && !field_tester_enable && power_down_n
		|=> state == svt_pkg::ST_TRAIN;
	endproperty
	a_train_start: assert property (p_train_start) else $error("training not started");

	property p_lock_done;
		@(posedge pclk) disable iff (!presetn)
		state == svt_pkg::ST_TRAIN && hpd_ok && !rx_lock_n && !field_tester_enable && power_down_n
		|=> state == svt_pkg::ST_NORMAL;
	endproperty
	a_lock_done: assert property (p_lock_done) else $error("lock ignored");

	property p_sync_word;
		@(posedge pclk) disable iff (!presetn)
		lane_valid && lane_kind == svt_pkg::KIND_SYNC |-> lane_word[34:3] == 32'h0 && !lane_word[0];
	endproperty
	a_sync_word: assert property (p_sync_word) else $error("sync word malformed");

	property p_pixel_word;
		@(posedge pclk) disable iff (!presetn)
		lane_valid && lane_kind == svt_pkg::KIND_PIXEL |-> lane_word == $past(cap_word) && lane_word[0];
	endproperty
	a_pixel_word: assert property (p_pixel_word) else $error("pixel word altered");
endmodule
`default_nettype wire

// ==== test/svt_host_model.sv ====
// Host video source model driving the parallel pixel bus.
`timescale 1ns/1ps
`default_nettype none
module svt_host_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [31:0] rnd,
	output logic pixel_clock_in,
	output logic [9:0] red_pixel_bits,
	output logic [9:0] green_pixel_bits,
	output logic [9:0] blue_pixel_bits,
	output logic [1:0] user_data_bits,
	output logic video_active,
	output logic line_sync,
	output logic frame_sync
);
	logic [1:0] phase; // Three pclk cycles per pixel clock level
	logic hold_act; // Active level only moves every second pixel
	// Pixel clock stands still while stopped; data moves mid-level so either edge sees it settled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 2'h0;
			hold_act <= 1'h0;
			pixel_clock_in <= 1'h0;
			{user_data_bits, red_pixel_bits, green_pixel_bits, blue_pixel_bits} <= 32'h0;
			{video_active, line_sync, frame_sync} <= 3'h0;
		end else if (run) begin
			phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
			if (phase == 2'h2) begin
				pixel_clock_in <= ~pixel_clock_in;
			end
			// New pixel once per period, never next to a capture edge
			if (phase == 2'h1 && pixel_clock_in) begin
				{user_data_bits, red_pixel_bits, green_pixel_bits, blue_pixel_bits} <= rnd;
				line_sync <= rnd[3] ^ rnd[17];
				frame_sync <= rnd[5] ^ rnd[20];
				hold_act <= ~hold_act;
				if (hold_act) begin
					video_active <= rnd[7] ^ rnd[25];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/svt_tx_frontend_bench.sv ====
// Self-checking bench of the serial video transmit front end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module svt_tx_frontend_bench;
	logic pclk, presetn, run, pixel_clock_in, video_active, line_sync, frame_sync;
	logic [31:0] rnd, pwdata, prdata, rd;
	logic [9:0] red_pixel_bits, green_pixel_bits, blue_pixel_bits;
	logic [1:0] user_data_bits, lane_kind, kind_e;
	logic power_down_n, width_select, low_freq_select, polarity_flip_n, edge_select;
	logic field_tester_enable, emphasis_select, swing_select, hot_plug_n, rx_lock_n;
	logic psel, penable, pwrite, pready, pslverr, er, lane_valid, serial_out_p, serial_out_n;
	logic emphasis_en, swing_normal, width24_mode, low_freq_mode;
	logic [11:0] paddr;
	logic [34:0] lane_word, cap_e, pat_exp;
	logic pc_prev, w24, lf_e, ctrl_e, train_chk;
	int errors, compares, npix, i;
	svt_tx_frontend i_svt_tx_frontend (.pclk(pclk), .presetn(presetn),
		.pixel_clock_in(pixel_clock_in), .red_pixel_bits(red_pixel_bits),
		.green_pixel_bits(green_pixel_bits), .blue_pixel_bits(blue_pixel_bits),
		.user_data_bits(user_data_bits), .video_active(video_active), .line_sync(line_sync),
		.frame_sync(frame_sync), .power_down_n(power_down_n), .width_select(width_select),
		.low_freq_select(low_freq_select), .polarity_flip_n(polarity_flip_n),
		.edge_select(edge_select), .field_tester_enable(field_tester_enable),
		.emphasis_select(emphasis_select), .swing_select(swing_select), .hot_plug_n(hot_plug_n),
		.rx_lock_n(rx_lock_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lane_word(lane_word), .lane_kind(lane_kind), .lane_valid(lane_valid),
		.serial_out_p(serial_out_p), .serial_out_n(serial_out_n), .emphasis_en(emphasis_en),
		.swing_normal(swing_normal), .width24_mode(width24_mode), .low_freq_mode(low_freq_mode));
	svt_host_model i_svt_host_model (.pclk(pclk), .presetn(presetn), .run(run), .rnd(rnd),
		.pixel_clock_in(pixel_clock_in), .red_pixel_bits(red_pixel_bits),
		.green_pixel_bits(green_pixel_bits), .blue_pixel_bits(blue_pixel_bits),
		.user_data_bits(user_data_bits), .video_active(video_active), .line_sync(line_sync),
		.frame_sync(frame_sync));
	// Free-running system clock
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	// Xorshift source of pixel values
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	always @(posedge pclk) rnd <= xs(rnd);
	// Status word from the bench's own view of straps and link state
	function automatic logic [31:0] stat_e(input logic [2:0] st);
		return {22'h0, power_down_n, swing_select & power_down_n, emphasis_select & power_down_n,
			lf_e, w24, ~hot_plug_n | ctrl_e, ~rx_lock_n, st};
	endfunction
	// Reference model: predicts each pixel and sync word from the pins seen at the capture edge
	always @(posedge pclk) begin
		if (presetn === 1'h1 && lane_valid === 1'h1) begin
			`CHK("serial p", ^lane_word, serial_out_p);
			`CHK("serial n", ~(^lane_word), serial_out_n);
			if (lane_kind === svt_pkg::KIND_PATTERN) begin
				if (train_chk) begin
					`CHK("train word", pat_exp, lane_word);
					pat_exp = ~pat_exp;
				end
			end else begin
				`CHK("lane kind", kind_e, lane_kind);
				`CHK("lane word", cap_e, lane_word);
				npix += (lane_kind === svt_pkg::KIND_PIXEL) ? 1 : 0;
			end
		end
		// Capture only in the selected direction of the pixel clock
		if (pixel_clock_in !== pc_prev && pixel_clock_in === edge_select) begin
			if (video_active ^ ~polarity_flip_n) begin
				cap_e = {user_data_bits, red_pixel_bits, green_pixel_bits, blue_pixel_bits,
					frame_sync, line_sync, 1'h1};
				if (w24) begin
					{cap_e[34:33], cap_e[24:23], cap_e[14:13], cap_e[4:3]} = 8'h0;
				end
				kind_e = svt_pkg::KIND_PIXEL;
			end else begin
				cap_e = {32'h0, frame_sync, line_sync, 1'h0};
				kind_e = svt_pkg::KIND_SYNC;
			end
		end
		pc_prev = pixel_clock_in;
	end
	// Verdict and end of run
	task print_verdict;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// One APB transfer; holds the request until pready is sampled high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, wr, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'h1) break;
		end
		if (n == 20) begin
			errors++;
			print_verdict;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Bounded wait for a lane word of a given kind
	task wait_kind(input logic [1:0] k);
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge pclk);
			if (lane_valid === 1'h1 && lane_kind === k) break;
		end
		if (n == 300) begin
			errors++;
			print_verdict;
		end
	endtask
	// Hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		errors++;
		print_verdict;
	end
	// Main sequence
	initial begin
		{presetn, run, psel, penable, pwrite, paddr, pwdata} = 49'h0;
		{power_down_n, width_select, low_freq_select, polarity_flip_n, edge_select} = 5'h11;
		{field_tester_enable, emphasis_select, swing_select, hot_plug_n, rx_lock_n} = 5'hF;
		{errors, compares, npix} = 96'h0;
		{pc_prev, w24, lf_e, ctrl_e, train_chk} = 5'h0;
		{cap_e, pat_exp, kind_e} = 72'h0;
		rnd = 32'h0000F9BB;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		repeat (3) @(posedge pclk);
		apb(1'h0, svt_pkg::REG_STATUS, 32'h0);
		`CHK("status wait", stat_e(3'h1), rd);
		apb(1'h0, 12'h00C, 32'h0);
		`CHK("unmapped err", 1'h1, er);
		`CHK("unmapped data", 32'h0, rd);
		// Training starts once the receiver pulls hot-plug low
		pat_exp = svt_pkg::TRAIN_PATTERN;
		train_chk = 1'h1;
		run <= 1'h1;
		hot_plug_n <= 1'h0;
		wait_kind(svt_pkg::KIND_PATTERN);
		repeat (30) @(posedge pclk);
		apb(1'h0, svt_pkg::REG_STATUS, 32'h0);
		`CHK("status train", stat_e(3'h2), rd);
		train_chk = 1'h0;
		rx_lock_n <= 1'h0;
		wait_kind(svt_pkg::KIND_PIXEL);
		apb(1'h0, svt_pkg::REG_STATUS, 32'h0);
		`CHK("status normal", stat_e(3'h3), rd);
		// Every capture edge and active polarity, pixel clock parked while switching
		for (i = 0; i < 4; i++) begin
			run <= 1'h0;
			repeat (8) @(posedge pclk);
			edge_select <= i[0];
			polarity_flip_n <= i[1];
			repeat (2) @(posedge pclk);
			run <= 1'h1;
			repeat (90) @(posedge pclk);
		end
		// Pixel counter cleared by a write, then counts exactly the pixel words
		run <= 1'h0;
		repeat (8) @(posedge pclk);
		apb(1'h1, svt_pkg::REG_PIXCNT, 32'h0);
		npix = 0;
		run <= 1'h1;
		repeat (120) @(posedge pclk);
		run <= 1'h0;
		repeat (8) @(posedge pclk);
		apb(1'h0, svt_pkg::REG_PIXCNT, 32'h0);
		`CHK("pixel count", npix, rd);
		// Power-down with new width and range straps, then the host toggles back up
		power_down_n <= 1'h0;
		width_select <= 1'h1;
		low_freq_select <= 1'h1;
		repeat (4) @(posedge pclk);
		`CHK("lines high", 2'h3, {serial_out_p, serial_out_n});
		`CHK("lane idle", svt_pkg::KIND_IDLE, lane_kind);
		apb(1'h0, svt_pkg::REG_STATUS, 32'h0);
		`CHK("status off", stat_e(3'h0), rd);
		power_down_n <= 1'h1;
		w24 = 1'h1;
		lf_e = 1'h1;
		repeat (4) @(posedge pclk);
		`CHK("width24", 1'h1, width24_mode);
		`CHK("low freq", 1'h1, low_freq_mode);
		run <= 1'h1;
		wait_kind(svt_pkg::KIND_PIXEL);
		repeat (150) @(posedge pclk);
		apb(1'h0, svt_pkg::REG_STATUS, 32'h0);
		`CHK("status 24", stat_e(3'h3), rd);
		// Emphasis and swing follow their straps
		for (i = 0; i < 4; i++) begin
			emphasis_select <= i[0];
			swing_select <= i[1];
			repeat (3) @(posedge pclk);
			`CHK("emphasis", i[0], emphasis_en);
			`CHK("swing", i[1], swing_normal);
		end
		// Bit-error test entry and exit
		field_tester_enable <= 1'h1;
		repeat (3) @(posedge pclk);
		apb(1'h0, svt_pkg::REG_STATUS, 32'h0);
		`CHK("status test", stat_e(3'h4), rd);
		wait_kind(svt_pkg::KIND_PATTERN);
		field_tester_enable <= 1'h0;
		wait_kind(svt_pkg::KIND_PIXEL);
		// Lock lost retrains; hot-plug lost waits; override bit restarts training
		rx_lock_n <= 1'h1;
		repeat (3) @(posedge pclk);
		apb(1'h0, svt_pkg::REG_STATUS, 32'h0);
		`CHK("status relock", stat_e(3'h2), rd);
		hot_plug_n <= 1'h1;
		repeat (3) @(posedge pclk);
		apb(1'h0, svt_pkg::REG_STATUS, 32'h0);
		`CHK("status unplug", stat_e(3'h1), rd);
		apb(1'h1, svt_pkg::REG_CTRL, 32'h1);
		ctrl_e = 1'h1;
		apb(1'h0, svt_pkg::REG_CTRL, 32'h0);
		`CHK("ctrl", 32'h1, rd);
		apb(1'h0, svt_pkg::REG_STATUS, 32'h0);
		`CHK("status forced", stat_e(3'h2), rd);
		print_verdict;
	end
endmodule
`default_nettype wire
